/* File: hdl/adc_measurement_sequencer.sv */
// measurement sequencer: control registers, channel order, averaging, serial port mode
// Summary of operation
// - after calibration the sequencer idles, powered, taking no measurements
// - setting monitor enable starts measuring in round-robin mode
// - round-robin order: supply, internal temp, external temp or inputs one/two, three..eight
// - after input eight the sequence returns straight to the supply channel
// - measuring continues until monitor enable is cleared
// - single-channel select bit switches to single-channel mode while monitoring
// - averaging is on from reset; each result averages 16 conversions
// - averaging disable bit makes each result a single conversion
// - two pin-function bits choose analog inputs one/two or external diode
// - reference select bit picks internal reference or supply as full scale
// - serial port starts in I2C mode after power-up
// - selecting SPI locks the port in SPI; I2C never locks
// - only a power cycle leaves SPI; no register write undoes it
// - speed select bit raises the conversion clock to the fast rate
// - slow speed at reset; fast speed turns off diode input filtering
// - in single-channel mode a four-bit field names the repeated channel
// - a serial transaction aborts and resets the conversion; restart afterwards
`default_nettype none
module adc_measurement_sequencer
  import adc_seq_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYCLES_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data_q,
  input wire logic txn_active,
  input wire logic spi_select,
  output logic spi_mode_q,
  input wire logic adc_done,
  input wire logic [9:0] adc_data,
  output adc_ctrl_s adc_ctrl_q,
  output meas_result_s result_q
);

  // register group
  logic [7:0] ctrl_one_q, ctrl_one_d;
  logic [7:0] ctrl_two_q, ctrl_two_d;
  logic [7:0] ctrl_three_q, ctrl_three_d;
  logic [7:0] rd_data_d;
  logic spi_mode_d;

  always_comb begin
    ctrl_one_d = ctrl_one_q;
    ctrl_two_d = ctrl_two_q;
    ctrl_three_d = ctrl_three_q;
    if (wr_en) begin
      unique case (wr_addr)
        ADDR_CTRL_ONE: ctrl_one_d = wr_data;
        ADDR_CTRL_TWO: ctrl_two_d = wr_data;
        ADDR_CTRL_THREE: ctrl_three_d = wr_data;
        default: ;
      endcase
    end
    unique case (rd_addr)
      ADDR_CTRL_ONE: rd_data_d = ctrl_one_q;
      ADDR_CTRL_TWO: rd_data_d = ctrl_two_q;
      ADDR_CTRL_THREE: rd_data_d = ctrl_three_q;
      default: rd_data_d = 8'h00;
    endcase
    // sticky until power cycle; no write path clears it
    spi_mode_d = spi_mode_q | spi_select;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_one_q <= CTRL_ONE_RESET;
      ctrl_two_q <= CTRL_TWO_RESET;
      ctrl_three_q <= CTRL_THREE_RESET;
      rd_data_q <= 8'h00;
      spi_mode_q <= 1'b0;
    end else begin
      ctrl_one_q <= ctrl_one_d;
      ctrl_two_q <= ctrl_two_d;
      ctrl_three_q <= ctrl_three_d;
      rd_data_q <= rd_data_d;
      spi_mode_q <= spi_mode_d;
    end
  end

  logic mon_en;
  logic single_mode;
  logic avg_off;
  logic ext_diode;
  logic fast;
  logic [3:0] sel_chan;

  assign mon_en = ctrl_one_q[MONITOR_ENABLE_POS];
  // both pin-function bits low leaves the shared pins on the diode
  assign ext_diode = ~(ctrl_one_q[PIN_FUNCTION_SELECT_LOW_POS] | ctrl_one_q[PIN_FUNCTION_SELECT_HIGH_POS]);
  assign single_mode = ctrl_two_q[SINGLE_CHANNEL_SELECT_POS];
  assign avg_off = ctrl_two_q[AVERAGING_DISABLE_POS];
  assign fast = ctrl_three_q[SPEED_SELECT_POS];
  // codes beyond the last input fall back to the supply channel
  assign sel_chan = (ctrl_two_q[CHANNEL_FIELD_MSB:CHANNEL_FIELD_LSB] > CH_AIN_EIGHT) ? CH_VDD :
                    ctrl_two_q[CHANNEL_FIELD_MSB:CHANNEL_FIELD_LSB];

  // sequencer group
  seq_state_e state_q, state_d;
  logic [19:0] cal_cnt_q, cal_cnt_d;
  logic [3:0] chan_q, chan_d;
  logic [3:0] samp_cnt_q, samp_cnt_d;
  logic [13:0] acc_q, acc_d;
  logic [13:0] acc_sum;
  logic [3:0] rr_next;
  logic [3:0] next_chan;
  logic first_sample_done;
  adc_ctrl_s adc_ctrl_d;
  meas_result_s result_d;

  always_comb begin
    unique case (chan_q)
      CH_VDD: rr_next = CH_INT_TEMP;
      CH_INT_TEMP: rr_next = ext_diode ? CH_EXT_TEMP : CH_AIN_ONE;
      CH_EXT_TEMP: rr_next = CH_AIN_THREE;
      CH_AIN_EIGHT: rr_next = CH_VDD;
      default: rr_next = chan_q + 4'h1;
    endcase
    next_chan = single_mode ? sel_chan : rr_next;
  end

  assign acc_sum = acc_q + {4'h0, adc_data};
  assign first_sample_done = avg_off || (samp_cnt_q == AVG_LAST);

  always_comb begin
    state_d = state_q;
    cal_cnt_d = cal_cnt_q;
    chan_d = chan_q;
    samp_cnt_d = samp_cnt_q;
    acc_d = acc_q;
    result_d = result_q;
    result_d.valid = 1'b0;
    adc_ctrl_d.start = 1'b0;
    adc_ctrl_d.reset = txn_active;
    adc_ctrl_d.chan = chan_q;
    adc_ctrl_d.fast = fast;
    adc_ctrl_d.diode_filter_en = ~fast;
    adc_ctrl_d.ref_from_supply = ctrl_three_q[REFERENCE_SELECT_POS];
    unique case (state_q)
      ST_CAL: begin
        if (cal_cnt_q == 20'(CAL_CYCLES - 1)) begin
          state_d = ST_IDLE;
        end else begin
          cal_cnt_d = cal_cnt_q + 20'h1;
        end
      end
      ST_IDLE: begin
        chan_d = single_mode ? sel_chan : CH_VDD;
        if (mon_en && !txn_active) begin
          state_d = ST_START;
        end
      end
      ST_START: begin
        adc_ctrl_d.start = !txn_active;
        if (!txn_active) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (adc_done) begin
          state_d = ST_START;
          if (first_sample_done) begin
            // publish only the finished average, never a partial sum
            result_d.valid = 1'b1;
            result_d.chan = chan_q;
            // single conversion taken as is, so a sum left from a mid-run switch never leaks
            result_d.data = avg_off ? adc_data : acc_sum[13:4];
            acc_d = 14'h0;
            samp_cnt_d = 4'h0;
            chan_d = next_chan;
          end else begin
            acc_d = acc_sum;
            samp_cnt_d = samp_cnt_q + 4'h1;
          end
        end
      end
    endcase
    if (state_q != ST_CAL && !mon_en) begin
      state_d = ST_IDLE;
      acc_d = 14'h0;
      samp_cnt_d = 4'h0;
      adc_ctrl_d.start = 1'b0;
      result_d.valid = 1'b0;
    end else if ((state_q == ST_START || state_q == ST_WAIT) && txn_active) begin
      // a transaction throws away the partial average and restarts the channel
      state_d = ST_START;
      acc_d = 14'h0;
      samp_cnt_d = 4'h0;
      result_d.valid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_CAL;
      cal_cnt_q <= 20'h0;
      chan_q <= CH_VDD;
      samp_cnt_q <= 4'h0;
      acc_q <= 14'h0;
      adc_ctrl_q <= '0;
      adc_ctrl_q.diode_filter_en <= 1'b1;
      result_q <= '0;
    end else begin
      state_q <= state_d;
      cal_cnt_q <= cal_cnt_d;
      chan_q <= chan_d;
      samp_cnt_q <= samp_cnt_d;
      acc_q <= acc_d;
      adc_ctrl_q <= adc_ctrl_d;
      result_q <= result_d;
    end
  end

  // checks
  a_idle_no_start: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == ST_IDLE) |=> !adc_ctrl_q.start) else $error("conversion started while idle");
  a_enable_starts: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == ST_IDLE && mon_en && !txn_active) ##1 (!txn_active && mon_en) |=>
      adc_ctrl_q.start && adc_ctrl_q.chan == $past(chan_q)) else $error("enable did not start");
  a_rr_after_vdd: assert property (@(posedge ref_clk) disable iff (rst)
    (result_d.valid && chan_q == CH_VDD && !single_mode) |=> chan_q == CH_INT_TEMP)
    else $error("round-robin order broken after supply");
  a_wrap_to_vdd: assert property (@(posedge ref_clk) disable iff (rst)
    (result_d.valid && chan_q == CH_AIN_EIGHT && !single_mode) |=>
      chan_q == CH_VDD ##1 (adc_ctrl_q.start || $past(txn_active) || !$past(mon_en)))
    else $error("no wrap to supply after input eight");
  a_single_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (result_d.valid && single_mode) |=> chan_q == $past(sel_chan)) else $error("single channel not held");
  a_avg_complete: assert property (@(posedge ref_clk) disable iff (rst)
    result_q.valid |-> $past(avg_off) || $past(samp_cnt_q) == AVG_LAST) else $error("partial average published");
  a_txn_abort: assert property (@(posedge ref_clk) disable iff (rst)
    txn_active |=> adc_ctrl_q.reset && !adc_ctrl_q.start && !result_q.valid) else $error("transaction did not abort");
  a_disable_idle: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q != ST_CAL && !mon_en) |=> state_q == ST_IDLE && $stable(result_q.data)) else $error("disable not honoured");
  a_spi_locked: assert property (@(posedge ref_clk) disable iff (rst)
    spi_mode_q |=> spi_mode_q) else $error("spi lock released");
  a_fast_no_filter: assert property (@(posedge ref_clk) disable iff (rst)
    fast [*2] |-> !adc_ctrl_q.diode_filter_en && adc_ctrl_q.fast) else $error("filter left active at fast speed");

  // calibration, idle and start-up
  a_cal_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == ST_CAL) |=> !adc_ctrl_q.start && !result_q.valid)
    else $error("activity during calibration");
  a_cal_to_idle: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == ST_CAL && cal_cnt_q == 20'(CAL_CYCLES - 1)) |=> state_q == ST_IDLE)
    else $error("calibration did not end in idle");
  a_idle_holds: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == ST_IDLE && !mon_en) |=> state_q == ST_IDLE)
    else $error("left idle without enable");
  a_start_rr_vdd: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == ST_IDLE && !single_mode) |=> chan_q == CH_VDD)
    else $error("round-robin start not at supply");

  // channel order
  a_rr_int_next: assert property (@(posedge ref_clk) disable iff (rst)
    (result_d.valid && chan_q == CH_INT_TEMP && !single_mode) |=> chan_q == ($past(ext_diode) ? CH_EXT_TEMP : CH_AIN_ONE))
    else $error("wrong channel after internal temperature");
  a_rr_ext_next: assert property (@(posedge ref_clk) disable iff (rst)
    (result_d.valid && chan_q == CH_EXT_TEMP && !single_mode) |=> chan_q == CH_AIN_THREE)
    else $error("wrong channel after external temperature");
  a_rr_step: assert property (@(posedge ref_clk) disable iff (rst)
    (result_d.valid && chan_q >= CH_AIN_ONE && chan_q < CH_AIN_EIGHT && !single_mode) |=> chan_q == $past(chan_q) + 4'h1)
    else $error("analog inputs out of order");

  // averaging, run and stop
  a_run_continues: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == ST_WAIT && adc_done && mon_en && !txn_active) |=> state_q == ST_START)
    else $error("measuring stopped while enabled");
  a_avg_off_single: assert property (@(posedge ref_clk) disable iff (rst)
    (result_q.valid && $past(avg_off)) |-> result_q.data == $past(adc_data))
    else $error("unaveraged result is not the conversion");

  // analog settings and serial port
  a_ref_follows: assert property (@(posedge ref_clk) disable iff (rst)
    adc_ctrl_q.ref_from_supply == $past(ctrl_three_q[REFERENCE_SELECT_POS]))
    else $error("reference select not applied");
  a_fast_follows: assert property (@(posedge ref_clk) disable iff (rst)
    adc_ctrl_q.fast == $past(fast))
    else $error("speed select not applied");
  a_slow_filter: assert property (@(posedge ref_clk) disable iff (rst)
    !fast [*2] |-> adc_ctrl_q.diode_filter_en && !adc_ctrl_q.fast)
    else $error("filter dropped at slow speed");
  a_spi_take: assert property (@(posedge ref_clk) disable iff (rst)
    spi_select |=> spi_mode_q)
    else $error("spi selection not locked");
  a_i2c_default: assert property (@(posedge ref_clk) disable iff (rst)
    (!spi_mode_q && !spi_select) |=> !spi_mode_q)
    else $error("left i2c without selection");

  // serial traffic
  a_txn_reset_level: assert property (@(posedge ref_clk) disable iff (rst)
    !txn_active |=> !adc_ctrl_q.reset)
    else $error("converter held in reset without traffic");
  a_txn_restart: assert property (@(posedge ref_clk) disable iff (rst)
    ($fell(txn_active) && state_q == ST_START && mon_en) |=> adc_ctrl_q.start)
    else $error("no restart after transaction");

endmodule
`default_nettype wire

/* File: hdl/adc_seq_pkg.sv */
// shared constants and carriers for the adc measurement sequencer
`default_nettype none
package adc_seq_pkg;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h18;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h19;
  localparam logic [7:0] ADDR_CTRL_THREE = 8'h1a;
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0] CTRL_THREE_RESET = 8'h00;
  // measurement control one fields
  localparam int MONITOR_ENABLE_POS = 0;
  localparam int PIN_FUNCTION_SELECT_LOW_POS = 1;
  localparam int PIN_FUNCTION_SELECT_HIGH_POS = 2;
  // measurement control two fields
  localparam int CHANNEL_FIELD_LSB = 0;
  localparam int CHANNEL_FIELD_MSB = 3;
  localparam int SINGLE_CHANNEL_SELECT_POS = 4;
  localparam int AVERAGING_DISABLE_POS = 5;
  // measurement control three fields
  localparam int SPEED_SELECT_POS = 0;
  localparam int REFERENCE_SELECT_POS = 4;
  // averaging
  localparam int AVG_SAMPLES = 16;
  localparam logic [3:0] AVG_LAST = 4'hf;
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int CAL_TIME_MS = 5;
  localparam int CAL_CYCLES_DEFAULT = (CAL_TIME_MS * 1000000) / CLK_PERIOD_NS;
  // channel codes
  localparam logic [3:0] CH_VDD = 4'h0;
  localparam logic [3:0] CH_INT_TEMP = 4'h1;
  localparam logic [3:0] CH_EXT_TEMP = 4'h2;
  localparam logic [3:0] CH_AIN_ONE = 4'h3;
  localparam logic [3:0] CH_AIN_TWO = 4'h4;
  localparam logic [3:0] CH_AIN_THREE = 4'h5;
  localparam logic [3:0] CH_AIN_EIGHT = 4'ha;

  typedef enum logic [1:0] {ST_CAL, ST_IDLE, ST_START, ST_WAIT} seq_state_e;

  typedef struct packed {
    logic start;
    logic reset;
    logic [3:0] chan;
    logic fast;
    logic diode_filter_en;
    logic ref_from_supply;
  } adc_ctrl_s;

  typedef struct packed {
    logic valid;
    logic [3:0] chan;
    logic [9:0] data;
  } meas_result_s;
endpackage
`default_nettype wire

/* File: tb/adc_model.sv */
// behavioural converter answering the sequencer's start pulses
`default_nettype none
module adc_model
  import adc_seq_pkg::*;
#(
  parameter int SLOW = 6,
  parameter int FAST = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire adc_ctrl_s ctrl,
  output logic adc_done,
  output logic [9:0] adc_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  int cnt;
  logic [3:0] k;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      cnt <= 0;
      k <= 4'h0;
      adc_done <= 1'b0;
      adc_data <= 10'h000;
    end else begin
      adc_done <= 1'b0;
      // code is only valid with done, so it keeps moving otherwise
      adc_data <= ~adc_data;
      if (ctrl.reset) begin
        busy <= 1'b0;
      end else if (ctrl.start) begin
        busy <= 1'b1;
        cnt <= ctrl.fast ? FAST : SLOW;
      end else if (busy && cnt == 0) begin
        busy <= 1'b0;
        adc_done <= 1'b1;
        adc_data <= {ctrl.chan, 2'b00, k};
        k <= k + 4'h1;
      end else if (busy) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/adc_measurement_sequencer_test.sv */
// self-checking bench for the measurement sequencer
`default_nettype none
module adc_measurement_sequencer_test
  import adc_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wr_en = 1'b0;
  logic [7:0] wr_addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] rd_addr = 8'h00;
  logic txn_active = 1'b0;
  logic spi_select = 1'b0;
  logic adc_done;
  logic spi_mode_q;
  logic [9:0] adc_data;
  logic [9:0] conv_q;
  logic [7:0] rd_data_q;
  adc_ctrl_s adc_ctrl_q;
  meas_result_s result_q;
  logic [3:0] ch;
  logic [9:0] d;
  int failures = 0;
  int check_count = 0;
  int starts = 0;
  int got_starts = 0;
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  adc_measurement_sequencer #(.CAL_CYCLES(16)) dut_u (.ref_clk(ref_clk), .rst(rst), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data_q(rd_data_q), .txn_active(txn_active),
    .spi_select(spi_select), .spi_mode_q(spi_mode_q), .adc_done(adc_done), .adc_data(adc_data),
    .adc_ctrl_q(adc_ctrl_q), .result_q(result_q));
  adc_model model_u (.ref_clk(ref_clk), .rst(rst), .ctrl(adc_ctrl_q), .adc_done(adc_done), .adc_data(adc_data));
  always @(posedge ref_clk) begin
    if (adc_ctrl_q.start === 1'b1) starts = starts + 1;
    if (adc_done === 1'b1) conv_q = adc_data;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= v;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    rd_addr <= a;
    cycles(2);
    check(16'(rd_data_q), 16'(exp));
  endtask
  // waits for one published result and takes the starts seen since the last
  task automatic next_result();
    int i;
    for (i = 0; i < 2000; i++) begin
      cycles(1);
      if (result_q.valid === 1'b1) break;
    end
    if (i == 2000) begin
      failures++;
      final_report();
    end
    ch = result_q.chan;
    d = result_q.data;
    got_starts = starts;
    starts = 0;
  endtask
  function automatic logic [3:0] next_ch(input logic [3:0] c, input logic dio);
    if (c == CH_AIN_EIGHT) return CH_VDD;
    if (c == CH_INT_TEMP) return dio ? CH_EXT_TEMP : CH_AIN_ONE;
    if (c == CH_EXT_TEMP) return CH_AIN_THREE;
    return c + 4'h1;
  endfunction
  task automatic s_idle();
    cycles(40);
    check(16'(starts), 16'h0);
    check(16'(spi_mode_q), 16'h0);
    check(16'({adc_ctrl_q.fast, adc_ctrl_q.diode_filter_en}), 16'h1);
    wr(8'h1b, 8'hff);
    rd_check(8'h1b, 8'h00);
    rd_check(ADDR_CTRL_ONE, CTRL_ONE_RESET);
    rd_check(ADDR_CTRL_TWO, CTRL_TWO_RESET);
    rd_check(ADDR_CTRL_THREE, CTRL_THREE_RESET);
  endtask
  task automatic s_average();
    wr(ADDR_CTRL_ONE, 8'h01);
    next_result();
    check(16'({ch, d}), 16'h0007);
    check(16'(got_starts), 16'd16);
    next_result();
    check(16'({ch, d}), 16'h0447);
  endtask
  task automatic s_round(input logic [7:0] c1);
    logic [3:0] exp_ch;
    int i;
    wr(ADDR_CTRL_ONE, c1);
    ch = 4'h0;
    for (i = 0; i < 20 && ch !== CH_AIN_EIGHT; i++) next_result();
    exp_ch = CH_VDD;
    repeat (10) begin
      next_result();
      check(16'(ch), 16'(exp_ch));
      check(16'(d[9:6]), 16'(exp_ch));
      check(16'(d), 16'(conv_q));
      check(16'(got_starts), 16'd1);
      exp_ch = next_ch(exp_ch, c1[2:1] == 2'b00);
    end
  endtask
  task automatic s_abort();
    @(posedge ref_clk);
    txn_active <= 1'b1;
    cycles(3);
    check(16'(adc_ctrl_q.reset), 16'h1);
    starts = 0;
    cycles(30);
    check(16'(starts), 16'h0);
    @(posedge ref_clk);
    txn_active <= 1'b0;
    next_result();
    check(16'(got_starts), 16'd1);
  endtask
  task automatic s_single();
    wr(ADDR_CTRL_TWO, 8'h37);
    next_result();
    repeat (3) begin
      next_result();
      check(16'(ch), 16'h7);
    end
    wr(ADDR_CTRL_THREE, 8'h11);
    cycles(3);
    check(16'({adc_ctrl_q.fast, adc_ctrl_q.diode_filter_en}), 16'h2);
    check(16'(adc_ctrl_q.ref_from_supply), 16'h1);
    rd_check(ADDR_CTRL_THREE, 8'h11);
  endtask
  task automatic s_stop();
    logic [13:0] r;
    wr(ADDR_CTRL_ONE, 8'h00);
    cycles(2);
    starts = 0;
    r = {result_q.chan, result_q.data};
    cycles(100);
    check(16'(starts), 16'h0);
    check(16'({result_q.chan, result_q.data}), 16'(r));
  endtask
  task automatic s_lock();
    @(posedge ref_clk);
    spi_select <= 1'b1;
    @(posedge ref_clk);
    spi_select <= 1'b0;
    cycles(2);
    check(16'(spi_mode_q), 16'h1);
    wr(ADDR_CTRL_ONE, 8'hff);
    wr(ADDR_CTRL_TWO, 8'hff);
    wr(ADDR_CTRL_THREE, 8'hff);
    cycles(2);
    check(16'(spi_mode_q), 16'h1);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    cycles(2);
    check(16'(spi_mode_q), 16'h0);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    s_idle();
    s_average();
    wr(ADDR_CTRL_TWO, 8'h20);
    s_round(8'h01);
    s_round(8'h07);
    s_abort();
    s_single();
    s_stop();
    s_lock();
    final_report();
  end
endmodule
`default_nettype wire
